// *** oam_pkg.sv ***
package oam_pkg;
	// ----------------------------------------
	// addressing modes
	// ----------------------------------------
	typedef enum logic [3:0] {
		OAM_MODE_SRC_IDX = 4'h0,
		OAM_MODE_DST_DIR = 4'h1,
		OAM_MODE_DST_IDX = 4'h2,
		OAM_MODE_DST_DIR_IMM = 4'h3,
		OAM_MODE_DST_IDX_IMM = 4'h4,
		OAM_MODE_MEM_MOVE = 4'h5,
		OAM_MODE_IND_SRC = 4'h6,
		OAM_MODE_IND_DST = 4'h7
	} oam_mode_t;

	// ----------------------------------------
	// executor states
	// ----------------------------------------
	typedef enum logic [2:0] {
		OAM_ST_IDLE = 3'h0,
		OAM_ST_READ = 3'h1,
		OAM_ST_PTR = 3'h2,
		OAM_ST_DATA = 3'h3,
		OAM_ST_WRITE = 3'h4,
		OAM_ST_INC = 3'h5,
		OAM_ST_DONE = 3'h6
	} oam_state_t;

	localparam logic [1:0] OAM_LEN_TWO = 2'h2;
	localparam logic [1:0] OAM_LEN_THREE = 2'h3;
	localparam logic [7:0] OAM_ACC_RST = 8'h00;
	localparam logic [7:0] OAM_IDX_RST = 8'h00;
	localparam logic [7:0] OAM_BYTE_ZERO = 8'h00;
	localparam logic [7:0] OAM_PTR_STEP = 8'h01;
	localparam int OAM_BANK_BIT = 4;
endpackage : oam_pkg

// *** oam_mode_decode.sv ***
`timescale 1ns/10ps
// ----------------------------------------
// per-mode length, indexed flag and address form
// ----------------------------------------
module oam_mode_decode (
	input wire oam_pkg::oam_mode_t mode_i,
	input wire logic [7:0] op1_i,
	input wire logic [7:0] idx_i,
	output logic [1:0] len_o,
	output logic [7:0] addr_o,
	output logic indexed_o
);
	always_comb begin
		indexed_o = 1'b0;
		len_o = oam_pkg::OAM_LEN_TWO;
		unique case (mode_i)
			oam_pkg::OAM_MODE_SRC_IDX,
			oam_pkg::OAM_MODE_DST_IDX: begin
				indexed_o = 1'b1;
			end
			oam_pkg::OAM_MODE_DST_IDX_IMM: begin
				indexed_o = 1'b1;
				len_o = oam_pkg::OAM_LEN_THREE;
			end
			oam_pkg::OAM_MODE_DST_DIR_IMM,
			oam_pkg::OAM_MODE_MEM_MOVE: begin
				len_o = oam_pkg::OAM_LEN_THREE;
			end
			oam_pkg::OAM_MODE_DST_DIR,
			oam_pkg::OAM_MODE_IND_SRC,
			oam_pkg::OAM_MODE_IND_DST: begin
			end
			default: begin
			end
		endcase
		// wraps at 8 bits, no carry out
		addr_o = indexed_o ? 8'(op1_i + idx_i) : op1_i;
	end
endmodule : oam_mode_decode

// *** oam_core.sv ***
`timescale 1ns/10ps
// Notes on behaviour
// - source indexed: operand1 plus X addresses source; result to A or X
// - source indexed arithmetic uses A or X as second operand; two bytes
// - destination direct: operand1 addresses result; location is second operand
// - destination direct source is A or X; that register stays unchanged
// - destination indexed: operand1 plus X addresses result and second operand
// - destination indexed source is always A; two bytes
// - direct destination with immediate operand2; three bytes
// - indexed destination with immediate operand2; three bytes
// - memory to memory direct only for move; three bytes
// - move copies RAM at operand2 into RAM at operand1; RAM only
// - indirect source: pointer read at operand1, then memory at pointer
// - byte at pointer loads A in the same cycle as the stored pointer increments
// - indirect destination: A written at pointer, then pointer increments
// - RAM and register space are separate; register form reaches registers
// - direct move to register space copies A or X, that register unchanged
// - register space has two banks of 256, chosen by flags bank bit
module oam_core (
	input wire logic core_clk_i,
	input wire logic nrst_i,
	input wire logic start_i,
	input wire oam_pkg::oam_mode_t mode_i,
	input wire logic reg_space_i,
	input wire logic is_arith_i,
	input wire logic use_x_i,
	input wire logic [7:0] op1_i,
	input wire logic [7:0] op2_i,
	input wire logic [7:0] flags_i,
	input wire logic acc_load_i,
	input wire logic idx_load_i,
	input wire logic [7:0] load_data_i,
	input wire logic [7:0] alu_result_i,
	input wire logic [7:0] ram_rdata_i,
	input wire logic [7:0] reg_rdata_i,
	output logic busy_o,
	output logic done_o,
	output logic [1:0] len_o,
	output logic [7:0] acc_o,
	output logic [7:0] idx_o,
	output logic [7:0] alu_a_o,
	output logic [7:0] alu_b_o,
	output logic ram_re_o,
	output logic ram_we_o,
	output logic [7:0] ram_addr_o,
	output logic [7:0] ram_wdata_o,
	output logic reg_re_o,
	output logic reg_we_o,
	output logic [8:0] reg_addr_o,
	output logic [7:0] reg_wdata_o
);
	// ----------------------------------------
	// state
	// ----------------------------------------
	oam_pkg::oam_state_t state_r;
	oam_pkg::oam_mode_t mode_r;
	logic reg_r;
	logic arith_r;
	logic use_x_r;
	logic bank_r;
	logic [7:0] op1_r;
	logic [7:0] op2_r;
	logic [7:0] addr_r;
	logic [7:0] ptr_r;
	logic [7:0] data_r;
	logic [7:0] acc_r;
	logic [7:0] idx_r;
	logic [1:0] len_r;
	logic [1:0] len_nxt;
	logic [7:0] addr_nxt;
	logic [7:0] rd_data;
	logic [7:0] src_val;
	logic is_dst;

	oam_mode_decode u_dec (
		.mode_i(mode_i),
		.op1_i(op1_i),
		.idx_i(idx_r),
		.len_o(len_nxt),
		.addr_o(addr_nxt),
		.indexed_o()
	);

	// RAM-only modes ignore the register-space form
	assign rd_data = reg_r ? reg_rdata_i : ram_rdata_i;
	assign is_dst = (mode_r != oam_pkg::OAM_MODE_SRC_IDX);

	always_comb begin
		unique case (mode_r)
			oam_pkg::OAM_MODE_DST_DIR: src_val = use_x_r ? idx_r : acc_r;
			oam_pkg::OAM_MODE_DST_IDX: src_val = acc_r;
			oam_pkg::OAM_MODE_DST_DIR_IMM,
			oam_pkg::OAM_MODE_DST_IDX_IMM: src_val = op2_r;
			default: src_val = use_x_r ? idx_r : acc_r;
		endcase
	end

	// ----------------------------------------
	// sequencer
	// ----------------------------------------
	always_ff @(posedge core_clk_i) begin
		if (!nrst_i) begin
			state_r <= oam_pkg::OAM_ST_IDLE;
			mode_r <= oam_pkg::OAM_MODE_SRC_IDX;
			reg_r <= 1'b0;
			arith_r <= 1'b0;
			use_x_r <= 1'b0;
			bank_r <= 1'b0;
			op1_r <= oam_pkg::OAM_BYTE_ZERO;
			op2_r <= oam_pkg::OAM_BYTE_ZERO;
			addr_r <= oam_pkg::OAM_BYTE_ZERO;
			ptr_r <= oam_pkg::OAM_BYTE_ZERO;
			data_r <= oam_pkg::OAM_BYTE_ZERO;
			len_r <= oam_pkg::OAM_LEN_TWO;
		end else begin
			unique case (state_r)
				oam_pkg::OAM_ST_IDLE: begin
					if (start_i) begin
						mode_r <= mode_i;
						// mem move and indirect reach RAM only
						reg_r <= reg_space_i && (mode_i != oam_pkg::OAM_MODE_MEM_MOVE)
							&& (mode_i != oam_pkg::OAM_MODE_IND_SRC) && (mode_i != oam_pkg::OAM_MODE_IND_DST);
						arith_r <= is_arith_i;
						use_x_r <= use_x_i;
						bank_r <= flags_i[oam_pkg::OAM_BANK_BIT];
						op1_r <= op1_i;
						op2_r <= op2_i;
						addr_r <= (mode_i == oam_pkg::OAM_MODE_MEM_MOVE) ? op2_i : addr_nxt;
						len_r <= len_nxt;
						state_r <= oam_pkg::OAM_ST_READ;
					end
				end
				oam_pkg::OAM_ST_READ: begin
					state_r <= oam_pkg::OAM_ST_DATA;
					if (mode_r == oam_pkg::OAM_MODE_IND_SRC || mode_r == oam_pkg::OAM_MODE_IND_DST) begin
						state_r <= oam_pkg::OAM_ST_PTR;
					end
				end
				oam_pkg::OAM_ST_PTR: begin
					ptr_r <= ram_rdata_i;
					state_r <= (mode_r == oam_pkg::OAM_MODE_IND_SRC) ? oam_pkg::OAM_ST_DATA : oam_pkg::OAM_ST_WRITE;
				end
				oam_pkg::OAM_ST_DATA: begin
					data_r <= rd_data;
					state_r <= is_dst ? oam_pkg::OAM_ST_WRITE : oam_pkg::OAM_ST_DONE;
					if (mode_r == oam_pkg::OAM_MODE_MEM_MOVE) begin
						addr_r <= op1_r;
					end
					if (mode_r == oam_pkg::OAM_MODE_IND_SRC) begin
						state_r <= oam_pkg::OAM_ST_INC;
					end
				end
				oam_pkg::OAM_ST_WRITE: begin
					state_r <= (mode_r == oam_pkg::OAM_MODE_IND_DST) ? oam_pkg::OAM_ST_INC : oam_pkg::OAM_ST_DONE;
				end
				oam_pkg::OAM_ST_INC: begin
					state_r <= oam_pkg::OAM_ST_DONE;
				end
				oam_pkg::OAM_ST_DONE: begin
					state_r <= oam_pkg::OAM_ST_IDLE;
				end
				default: begin
					state_r <= oam_pkg::OAM_ST_IDLE;
				end
			endcase
		end
	end

	// ----------------------------------------
	// accumulator and index
	// ----------------------------------------
	always_ff @(posedge core_clk_i) begin
		if (!nrst_i) begin
			acc_r <= oam_pkg::OAM_ACC_RST;
			idx_r <= oam_pkg::OAM_IDX_RST;
		end else if (state_r == oam_pkg::OAM_ST_DONE && mode_r == oam_pkg::OAM_MODE_SRC_IDX) begin
			if (use_x_r) begin
				idx_r <= arith_r ? alu_result_i : data_r;
			end else begin
				acc_r <= arith_r ? alu_result_i : data_r;
			end
		end else if (state_r == oam_pkg::OAM_ST_INC && mode_r == oam_pkg::OAM_MODE_IND_SRC) begin
			// pointed byte is on the read bus in this cycle
			acc_r <= ram_rdata_i;
		end else if (state_r == oam_pkg::OAM_ST_IDLE) begin
			if (acc_load_i) begin
				acc_r <= load_data_i;
			end
			if (idx_load_i) begin
				idx_r <= load_data_i;
			end
		end
	end

	// ----------------------------------------
	// memory ports
	// ----------------------------------------
	always_comb begin
		ram_re_o = 1'b0;
		ram_we_o = 1'b0;
		ram_addr_o = addr_r;
		ram_wdata_o = oam_pkg::OAM_BYTE_ZERO;
		reg_re_o = 1'b0;
		reg_we_o = 1'b0;
		reg_addr_o = {bank_r, addr_r};
		reg_wdata_o = oam_pkg::OAM_BYTE_ZERO;
		unique case (state_r)
			oam_pkg::OAM_ST_READ: begin
				ram_re_o = !reg_r;
				reg_re_o = reg_r;
				if (mode_r == oam_pkg::OAM_MODE_IND_SRC || mode_r == oam_pkg::OAM_MODE_IND_DST) begin
					ram_addr_o = op1_r;
				end
				if (!arith_r && is_dst && mode_r != oam_pkg::OAM_MODE_MEM_MOVE
						&& mode_r != oam_pkg::OAM_MODE_IND_SRC && mode_r != oam_pkg::OAM_MODE_IND_DST) begin
					ram_re_o = 1'b0;
					reg_re_o = 1'b0;
				end
			end
			oam_pkg::OAM_ST_DATA: begin
				if (mode_r == oam_pkg::OAM_MODE_IND_SRC) begin
					ram_re_o = 1'b1;
					ram_addr_o = ptr_r;
				end
			end
			oam_pkg::OAM_ST_WRITE: begin
				if (mode_r == oam_pkg::OAM_MODE_IND_DST) begin
					ram_we_o = 1'b1;
					ram_addr_o = ptr_r;
					ram_wdata_o = acc_r;
				end else if (mode_r == oam_pkg::OAM_MODE_MEM_MOVE) begin
					ram_we_o = 1'b1;
					ram_wdata_o = data_r;
				end else begin
					ram_we_o = !reg_r;
					reg_we_o = reg_r;
					ram_wdata_o = arith_r ? alu_result_i : src_val;
					reg_wdata_o = arith_r ? alu_result_i : src_val;
				end
			end
			oam_pkg::OAM_ST_INC: begin
				ram_we_o = 1'b1;
				ram_addr_o = op1_r;
				ram_wdata_o = 8'(ptr_r + oam_pkg::OAM_PTR_STEP);
			end
			default: begin
			end
		endcase
	end

	// alu: a is the source, b the location or A/X second operand
	assign alu_a_o = is_dst ? src_val : data_r;
	assign alu_b_o = is_dst ? data_r : src_val;
	assign busy_o = (state_r != oam_pkg::OAM_ST_IDLE);
	assign done_o = (state_r == oam_pkg::OAM_ST_DONE);
	assign len_o = len_r;
	assign acc_o = acc_r;
	assign idx_o = idx_r;
endmodule : oam_core

// *** oam_core_props.sv ***
`timescale 1ns/10ps
// ----
// oam checks
// ----
module oam_core_props (
	input wire logic core_clk_i,
	input wire logic nrst_i,
	input wire logic start_i,
	input wire oam_pkg::oam_mode_t mode_i,
	input wire logic reg_space_i,
	input wire logic [7:0] flags_i,
	input wire logic [7:0] ram_rdata_i,
	input wire logic busy_o,
	input wire logic done_o,
	input wire logic [1:0] len_o,
	input wire logic [7:0] acc_o,
	input wire logic ram_re_o,
	input wire logic ram_we_o,
	input wire logic [7:0] ram_wdata_o,
	input wire logic reg_we_o,
	input wire logic [8:0] reg_addr_o
);
	default clocking cb @(posedge core_clk_i); endclocking
	default disable iff (!nrst_i);
	wire logic tk = start_i && !busy_o;
	wire logic bk = flags_i[oam_pkg::OAM_BANK_BIT];
	a_len_two: assert property (tk && mode_i inside {4'h0, 4'h1, 4'h2, 4'h6, 4'h7}
		|=> ##[0:4] (done_o && len_o == 2'h2)) else $error("two byte length wrong");
	a_len_three: assert property (tk && mode_i inside {4'h3, 4'h4, 4'h5}
		|=> ##[0:4] (done_o && len_o == 2'h3)) else $error("three byte length wrong");
	a_src_done: assert property (tk && mode_i == 4'h0 |-> ##3 done_o) else $error("source done late");
	a_wr_done: assert property (tk && mode_i inside {4'h1, 4'h2, 4'h3, 4'h4, 4'h5} |-> ##4 done_o)
		else $error("write done late");
	a_ind_src: assert property (tk && mode_i == 4'h6 |-> ##1 ram_re_o ##2 ram_re_o
		##1 (ram_we_o && ram_wdata_o == $past(ram_rdata_i, 2) + 8'h01) ##1 done_o) else $error("indirect read bad");
	a_ind_acc: assert property (tk && mode_i == 4'h6 |-> ##5 acc_o == $past(ram_rdata_i, 1))
		else $error("pointed byte not in acc");
	a_ind_dst: assert property (tk && mode_i == 4'h7 |-> ##1 ram_re_o ##2 (ram_we_o && ram_wdata_o == acc_o)
		##1 (ram_we_o && ram_wdata_o == $past(ram_rdata_i, 2) + 8'h01) ##1 done_o) else $error("indirect write bad");
	a_acc_kept: assert property (tk && mode_i == 4'h1 |=> $stable(acc_o) [*4]) else $error("acc changed");
	a_move_ram: assert property (tk && mode_i == 4'h5 |-> ##3 ram_we_o && !reg_we_o) else $error("move left ram");
	a_reg_bank: assert property (tk && mode_i == 4'h1 && reg_space_i
		|-> ##3 reg_we_o && !ram_we_o && reg_addr_o[8] == $past(bk, 3)) else $error("register form wrong");
	a_done_pulse: assert property (done_o |=> !done_o && !busy_o) else $error("done not one pulse");
	c_ind: cover property (tk && mode_i == 4'h6);
	c_reg: cover property (tk && mode_i == 4'h1 && reg_space_i);
	c_move: cover property (tk && mode_i == 4'h5);
endmodule : oam_core_props

bind oam_core oam_core_props u_oam_core_props (.*);

// *** tb_oam_core.sv ***
`timescale 1ns/10ps
// ----
// oam bench
// ----
module tb_oam_core;
	logic core_clk_i = 1'b0;
	logic nrst_i = 1'b0;
	logic start_i = 1'b0, reg_space_i = 1'b0, is_arith_i = 1'b0, use_x_i = 1'b0, acc_load_i = 1'b0, idx_load_i = 1'b0;
	oam_pkg::oam_mode_t mode_i = oam_pkg::OAM_MODE_SRC_IDX;
	logic [7:0] op1_i = 8'h00, op2_i = 8'h00, flags_i = 8'h00, load_data_i = 8'h00;
	logic [7:0] ram_rdata_i = 8'h00, reg_rdata_i = 8'h00, alu_result_i;
	logic busy_o, done_o, ram_re_o, ram_we_o, reg_re_o, reg_we_o, done_d;
	logic [1:0] len_o;
	logic [7:0] acc_o, idx_o, alu_a_o, alu_b_o, ram_addr_o, ram_wdata_o, reg_wdata_o;
	logic [8:0] reg_addr_o;
	logic [7:0] ram [256];
	logic [7:0] rgs [512];
	logic [17:0] wq [$];
	logic [17:0] sq [$];
	logic [31:0] seed = 32'hD007D9EB;
	int err_count = 0, checked = 0, cyc = 0;
	assign alu_result_i = alu_a_o + alu_b_o;
	oam_core u_oam_core (.*);
	always #5 core_clk_i = ~core_clk_i;
	function automatic logic [31:0] xs(input logic [31:0] s);
		s ^= s << 13;
		s ^= s >> 17;
		s ^= s << 5;
		return s;
	endfunction : xs
	task automatic final_report();
		if (wq.size() + sq.size() != 0) begin
			err_count++;
			$display("[FAIL] %0t %0d expected results never seen", $time, wq.size() + sq.size());
		end
		$display("checked %0d mismatches %0d", checked, err_count);
		if (err_count == 0 && checked > 0) begin
			$display("STATUS OK");
		end else begin
			$display("STATUS NOT OK");
		end
		$finish;
	endtask : final_report
	task automatic cmp_wr(input logic [17:0] g);
		logic [17:0] e;
		e = wq.size() ? wq.pop_front() : ~g;
		checked++;
		if (e !== g) begin
			err_count++;
			$display("[FAIL] %0t write %h exp %h", $time, g, e);
		end
		if (e[17]) rgs[e[16:8]] = e[7:0];
		else ram[e[15:8]] = e[7:0];
	endtask : cmp_wr
	task automatic cmp_st(input logic [17:0] g);
		logic [17:0] e;
		e = sq.size() ? sq.pop_front() : ~g;
		checked++;
		if (e !== g) begin
			err_count++;
			$display("[FAIL] %0t state %h exp %h", $time, g, e);
		end
	endtask : cmp_st
	always @(posedge core_clk_i) begin
		ram_rdata_i <= ram_re_o ? ram[ram_addr_o] : ~ram_rdata_i;
		reg_rdata_i <= reg_re_o ? rgs[reg_addr_o] : ~reg_rdata_i;
		done_d <= done_o;
		cyc <= cyc + 1;
		if (ram_we_o === 1'b1) begin
			cmp_wr({2'b00, ram_addr_o, ram_wdata_o});
		end
		if (reg_we_o === 1'b1) begin
			cmp_wr({1'b1, reg_addr_o, reg_wdata_o});
		end
		if (done_d === 1'b1) begin
			cmp_st({len_o, acc_o, idx_o});
		end
		if (cyc == 12000) begin
			err_count++;
			$display("[FAIL] %0t cycle limit reached", $time);
			final_report();
		end
	end
	task automatic run(input int m);
		logic [7:0] a, x, o1, o2, loc, src, ptr, v;
		logic sp, ar, ux, bk;
		int n;
		seed = xs(seed);
		{a, x, o1, o2} = seed;
		seed = xs(seed);
		{sp, ar, ux, bk} = seed[3:0];
		if (m >= 5) ar = 1'b0;
		@(posedge core_clk_i);
		acc_load_i <= 1'b1;
		load_data_i <= a;
		@(posedge core_clk_i);
		acc_load_i <= 1'b0;
		idx_load_i <= 1'b1;
		load_data_i <= x;
		loc = (m == 0 || m == 2 || m == 4) ? o1 + x : o1;
		v = (sp && m < 5) ? rgs[{bk, loc}] : ram[loc];
		src = m >= 3 ? o2 : ((ux && m < 2) ? x : a);
		ptr = ram[o1];
		case (m)
			0: if (ux) x = ar ? v + x : v;
				else a = ar ? v + a : v;
			5: wq.push_back({2'b00, o1, ram[o2]});
			6: begin
				a = ram[ptr];
				wq.push_back({2'b00, o1, ptr + 8'h01});
			end
			7: begin
				wq.push_back({2'b00, ptr, a});
				wq.push_back({2'b00, o1, ptr + 8'h01});
			end
			default: wq.push_back({sp, sp & bk, loc, ar ? src + v : src});
		endcase
		sq.push_back({(m >= 3 && m <= 5) ? 2'h3 : 2'h2, a, x});
		@(posedge core_clk_i);
		idx_load_i <= 1'b0;
		start_i <= 1'b1;
		mode_i <= oam_pkg::oam_mode_t'(m);
		{reg_space_i, is_arith_i, use_x_i, op1_i, op2_i} <= {sp, ar, ux, o1, o2};
		flags_i <= {3'h0, bk, seed[7:4]};
		@(posedge core_clk_i);
		start_i <= 1'b0;
		n = 0;
		do @(posedge core_clk_i); while (busy_o === 1'b1 && n++ < 10);
		if (busy_o === 1'b1) begin
			err_count++;
			$display("[FAIL] %0t mode %0d never finished", $time, m);
		end
	endtask : run
	initial begin
		for (int i = 0; i < 512; i++) begin
			seed = xs(seed);
			rgs[i] = seed[7:0];
			ram[i % 256] = seed[15:8];
		end
		repeat (16) @(posedge core_clk_i);
		nrst_i <= 1'b1;
		for (int m = 0; m < 8; m++) begin
			repeat (40) run(m);
			$display("test mode %0d done", m);
		end
		repeat (4) @(posedge core_clk_i);
		final_report();
	end
endmodule : tb_oam_core
